/* pkg/bvs_pkg.sv */
// Function
// RQ1: tick is oscillator divided by two to thirteen
// RQ2: tick near 33 Hz, period near 30 ms; the 250 kHz OSC_HZ gives about 30.5 Hz, 32.8 ms
// RQ3: held 3.5 ticks gives first step
// RQ4: second step after further 9.5 ticks
// RQ5: then one step every 2 ticks
// RQ6: short pulse one step, hold ramps
// RQ7: both inputs high, gain unchanged
// RQ8: 64 steps, lowest to highest gain
// RQ9: power-up or volume reset loads step 13
// RQ10: mute keeps stored gain step
// RQ11: mute low disables outputs at once
// RQ12: undriven mute reads high, outputs enabled
// RQ13: power down low turns bias, outputs off
// RQ14: host must drive power down high
// RQ15: gain saturates at both ends
// RQ16: both low, no step, timing restarts
//
// package of constants for the button volume stepper.
// assumes a 40 MHz mclk_i; all pins are synchronous to it.
package bvs_pkg;

   // =====================================================
   // clock and tick time base
   localparam int MCLK_HZ = 40_000_000;
   localparam int OSC_HZ = 250_000;
   localparam int CLK_PER_OSC = MCLK_HZ / OSC_HZ;
   localparam int TICK_DIV_LOG2 = 13;
   localparam int OSC_PER_TICK = 2 ** TICK_DIV_LOG2;
   // hold timing is counted in half ticks so 3.5 and 9.5 stay whole
   localparam int OSC_PER_HALF_TICK = OSC_PER_TICK / 2;
   localparam int TICK_HZ_NOM = 33;
   localparam int TICK_PERIOD_MS_NOM = 30;

   // =====================================================
   // hold-to-repeat delays, in half ticks
   localparam int HOLD_W = 5;
   localparam logic [HOLD_W-1:0] FIRST_HALVES = 5'h07;
   localparam logic [HOLD_W-1:0] SECOND_HALVES = 5'h13;
   localparam logic [HOLD_W-1:0] REPEAT_HALVES = 5'h04;

   // =====================================================
   // gain step encoding: index 0 is step 1, index 63 is step 64
   localparam int STEP_COUNT = 64;
   localparam int STEP_W = 6;
   localparam logic [STEP_W-1:0] STEP_MIN = 6'h00;
   localparam logic [STEP_W-1:0] STEP_MAX = 6'h3F;
   localparam logic [STEP_W-1:0] STEP_RESET = 6'h0C;
   // -75.0 dB in tenths needs eleven signed bits
   localparam int GAIN_W = 11;

   // =====================================================
   // hold sequencer states
   typedef enum logic [1:0] {
      BVS_IDLE = 2'b00,
      BVS_FIRST = 2'b01,
      BVS_SECOND = 2'b10,
      BVS_REPEAT = 2'b11
   } bvs_hold_e;

endpackage

/* hdl/bvs_pulse_div.sv */
// one-cycle enable divider: pulses once every DIV enabled cycles.
// assumes a single clock and a synchronous active-high reset.
module bvs_pulse_div #(
   parameter int DIV = 2
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic en_i,
   output logic pulse_o
);
   localparam int CW = $clog2(DIV) + 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_q;

   // =====================================================
   // counter and pulse
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
         pulse_o <= 1'b0;
      end else begin
         pulse_o <= 1'b0;
         if (en_i) begin
            if (cnt_q == LAST) begin
               cnt_q <= '0;
               pulse_o <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end
endmodule

/* hdl/bvs_gain_ctr.sv */
// saturating 64-entry gain step counter with default load.
// assumes step pulses are one cycle and never both high.
module bvs_gain_ctr (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic up_i,
   input wire logic down_i,
   output logic [bvs_pkg::STEP_W-1:0] step_o
);
   // =====================================================
   // load wins over stepping; ends clamp instead of wrapping
   always_ff @(posedge mclk_i) begin
      if (rst_i || load_i) begin
         step_o <= bvs_pkg::STEP_RESET; // RQ9
      end else if (up_i && step_o != bvs_pkg::STEP_MAX) begin
         step_o <= step_o + 1'b1; // RQ15
      end else if (down_i && step_o != bvs_pkg::STEP_MIN) begin
         step_o <= step_o - 1'b1; // RQ15
      end
   end
endmodule

/* hdl/bvs_stepper.sv */
// top of the button volume stepper: tick divider, hold sequencer,
// gain step store with dB lookup, mute and power-down output control.
// assumes all pins synchronous to mclk_i; pull resistors live at the pad.
module bvs_stepper #(
   parameter int CLK_PER_OSC = bvs_pkg::CLK_PER_OSC,
   parameter int OSC_PER_HALF_TICK = bvs_pkg::OSC_PER_HALF_TICK
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic volume_raise_n_i,
   input wire logic volume_lower_n_i,
   input wire logic volume_reset_n_i,
   input wire logic mute_n_i,
   input wire logic power_down_n_i,
   output logic [bvs_pkg::STEP_W-1:0] gain_step_o,
   output logic signed [bvs_pkg::GAIN_W-1:0] gain_db_x10_o,
   output logic outputs_enable_o,
   output logic bias_enable_o,
   output logic half_tick_o
);
   // gain per step in tenths of a dB, index 0 is step 1
   localparam logic signed [bvs_pkg::GAIN_W-1:0] GAIN_TBL [0:63] = '{
      -11'sd750, -11'sd397, -11'sd340, -11'sd282, -11'sd224, -11'sd165, -11'sd105, -11'sd80,
      -11'sd55, -11'sd29, -11'sd4, 11'sd11, 11'sd26, 11'sd36, 11'sd40, 11'sd44,
      11'sd48, 11'sd51, 11'sd55, 11'sd59, 11'sd63, 11'sd67, 11'sd71, 11'sd75,
      11'sd79, 11'sd83, 11'sd87, 11'sd91, 11'sd96, 11'sd100, 11'sd104, 11'sd107,
      11'sd112, 11'sd116, 11'sd120, 11'sd123, 11'sd127, 11'sd132, 11'sd136, 11'sd140,
      11'sd144, 11'sd148, 11'sd152, 11'sd156, 11'sd160, 11'sd164, 11'sd168, 11'sd172,
      11'sd176, 11'sd180, 11'sd184, 11'sd188, 11'sd192, 11'sd196, 11'sd200, 11'sd204,
      11'sd209, 11'sd213, 11'sd217, 11'sd221, 11'sd225, 11'sd229, 11'sd234, 11'sd238
   }; // RQ8

   logic osc_en;
   logic half_tick;
   logic raise_act;
   logic lower_act;
   logic single_act;
   bvs_pkg::bvs_hold_e state_q;
   logic [bvs_pkg::HOLD_W-1:0] hold_cnt_q;
   logic dir_up_q;
   logic step_up_q;
   logic step_dn_q;
   logic [bvs_pkg::HOLD_W-1:0] target;
   logic [bvs_pkg::STEP_W-1:0] step;

   // =====================================================
   // time base: mclk -> oscillator rate -> half tick
   bvs_pulse_div #(.DIV(CLK_PER_OSC)) u_osc_div (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .en_i(1'b1),
      .pulse_o(osc_en)
   );

   // two half ticks make one tick of oscillator / 2^13
   bvs_pulse_div #(.DIV(OSC_PER_HALF_TICK)) u_tick_div (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .en_i(osc_en),
      .pulse_o(half_tick)
   ); // RQ1 RQ2

   // =====================================================
   // button decode: exactly one low input counts as a press
   assign raise_act = ~volume_raise_n_i;
   assign lower_act = ~volume_lower_n_i;
   assign single_act = raise_act ^ lower_act; // RQ7 RQ16

   // delay to wait for in the current phase
   always_comb begin
      case (state_q)
         bvs_pkg::BVS_FIRST: target = bvs_pkg::FIRST_HALVES; // RQ3
         bvs_pkg::BVS_SECOND: target = bvs_pkg::SECOND_HALVES; // RQ4
         bvs_pkg::BVS_REPEAT: target = bvs_pkg::REPEAT_HALVES; // RQ5
         default: target = bvs_pkg::FIRST_HALVES;
      endcase
   end

   // =====================================================
   // hold sequencer; a release, a double press or a direction flip
   // restarts from the first delay so a short pulse steps only once
   always_ff @(posedge mclk_i) begin
      if (rst_i || !single_act || !power_down_n_i) begin
         state_q <= bvs_pkg::BVS_IDLE; // RQ16
         hold_cnt_q <= '0;
         dir_up_q <= 1'b0;
      end else if (state_q == bvs_pkg::BVS_IDLE || dir_up_q != raise_act) begin
         state_q <= bvs_pkg::BVS_FIRST; // RQ6
         hold_cnt_q <= '0;
         dir_up_q <= raise_act;
      end else if (half_tick) begin
         if (hold_cnt_q + 1'b1 == target) begin
            hold_cnt_q <= '0;
            case (state_q)
               bvs_pkg::BVS_FIRST: state_q <= bvs_pkg::BVS_SECOND; // RQ4
               bvs_pkg::BVS_SECOND: state_q <= bvs_pkg::BVS_REPEAT; // RQ5
               bvs_pkg::BVS_REPEAT: state_q <= bvs_pkg::BVS_REPEAT;
               default: state_q <= bvs_pkg::BVS_IDLE;
            endcase
         end else begin
            hold_cnt_q <= hold_cnt_q + 1'b1;
         end
      end
   end

   // step pulses, same cycle as each phase completion
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         step_up_q <= 1'b0;
         step_dn_q <= 1'b0;
      end else begin
         step_up_q <= 1'b0;
         step_dn_q <= 1'b0;
         if (single_act && power_down_n_i && state_q != bvs_pkg::BVS_IDLE && dir_up_q == raise_act &&
             half_tick && hold_cnt_q + 1'b1 == target) begin
            step_up_q <= dir_up_q; // RQ3 RQ6
            step_dn_q <= ~dir_up_q;
         end
      end
   end

   // =====================================================
   // gain store; mute never touches it so unmute restores the level
   bvs_gain_ctr u_gain (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .load_i(~volume_reset_n_i), // RQ9
      .up_i(step_up_q),
      .down_i(step_dn_q),
      .step_o(step)
   ); // RQ10 RQ15

   // =====================================================
   // registered outputs; mute is a hard gate with no fade
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         gain_step_o <= bvs_pkg::STEP_RESET;
         gain_db_x10_o <= GAIN_TBL[bvs_pkg::STEP_RESET];
         outputs_enable_o <= 1'b0;
         bias_enable_o <= 1'b0;
         half_tick_o <= 1'b0;
      end else begin
         gain_step_o <= step; // RQ10
         gain_db_x10_o <= GAIN_TBL[step]; // RQ8
         // pad pull-up makes a floating mute read high
         outputs_enable_o <= mute_n_i & power_down_n_i; // RQ11 RQ12 RQ13
         bias_enable_o <= power_down_n_i; // RQ13 RQ14
         half_tick_o <= half_tick;
      end
   end
endmodule

/* bench/bvs_button_model.sv */
// push-button model for the stepper's raise and lower pins.
// assumes the bench changes the press code at the falling edge.
module bvs_button_model (
   input wire logic [1:0] press_i,
   output logic volume_raise_n_o,
   output logic volume_lower_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====================================================
   // code 1 raise, 2 lower, 3 both; pins stay low for the whole hold
   assign volume_raise_n_o = !press_i[0];
   assign volume_lower_n_o = !press_i[1];
endmodule

/* bench/bvs_stepper_monitor.sv */
// checker bound to the stepper top, watching its ports only.
// assumes one clock domain with a sync active-high reset.
module bvs_stepper_monitor (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic volume_raise_n_i,
   input wire logic volume_lower_n_i,
   input wire logic volume_reset_n_i,
   input wire logic mute_n_i,
   input wire logic power_down_n_i,
   input wire logic [bvs_pkg::STEP_W-1:0] gain_step_o,
   input wire logic signed [bvs_pkg::GAIN_W-1:0] gain_db_x10_o,
   input wire logic outputs_enable_o,
   input wire logic bias_enable_o,
   input wire logic half_tick_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] ht_q;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // =====================================================
   // half ticks since the last step; reloads do not clear it, a held button may step soon after
   always_ff @(posedge mclk_i) begin
      if (rst_i || ($changed(gain_step_o) && $past(volume_reset_n_i, 2))) ht_q <= 4'h0;
      else if (half_tick_o && ht_q != 4'hF) ht_q <= ht_q + 4'h1;
   end
   property p_rst; disable iff (1'b0) rst_i |=> gain_step_o == bvs_pkg::STEP_RESET && !outputs_enable_o; endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_vres; (!volume_reset_n_i)[*2] |=> gain_step_o == bvs_pkg::STEP_RESET; endproperty
   a_vres: assert property (p_vres) else $error("volume reset not loaded");
   property p_db; gain_step_o == bvs_pkg::STEP_RESET |-> gain_db_x10_o == 11'h01A; endproperty
   a_db: assert property (p_db) else $error("default gain wrong");
   property p_idle;
      (volume_raise_n_i && volume_lower_n_i && volume_reset_n_i)[*6] |-> $stable(gain_step_o);
   endproperty
   a_idle: assert property (p_idle) else $error("gain moved while idle");
   property p_both;
      (!volume_raise_n_i && !volume_lower_n_i && volume_reset_n_i)[*6] |-> $stable(gain_step_o);
   endproperty
   a_both: assert property (p_both) else $error("gain moved with both low");
   property p_pd; (!power_down_n_i && volume_reset_n_i)[*6] |-> $stable(gain_step_o); endproperty
   a_pd: assert property (p_pd) else $error("gain moved in power down");
   property p_gap; $changed(gain_step_o) && !$past(rst_i) && $past(volume_reset_n_i, 2) |-> ht_q >= 4'h4; endproperty
   a_gap: assert property (p_gap) else $error("steps too close");
   property p_out; 1'b1 |=> outputs_enable_o == ($past(mute_n_i) && $past(power_down_n_i)); endproperty
   a_out: assert property (p_out) else $error("output enable wrong");
   property p_wrap; gain_step_o == bvs_pkg::STEP_MAX |=> gain_step_o != bvs_pkg::STEP_MIN; endproperty
   a_wrap: assert property (p_wrap) else $error("gain wrapped");
   c_step: cover property ($changed(gain_step_o));
   c_top: cover property (gain_step_o == bvs_pkg::STEP_MAX);
   c_mute: cover property ($fell(outputs_enable_o) && bias_enable_o);
endmodule

bind bvs_stepper bvs_stepper_monitor u_mon (.mclk_i(mclk_i), .rst_i(rst_i), .volume_raise_n_i(volume_raise_n_i),
   .volume_lower_n_i(volume_lower_n_i), .volume_reset_n_i(volume_reset_n_i), .mute_n_i(mute_n_i),
   .power_down_n_i(power_down_n_i), .gain_step_o(gain_step_o), .gain_db_x10_o(gain_db_x10_o),
   .outputs_enable_o(outputs_enable_o), .bias_enable_o(bias_enable_o), .half_tick_o(half_tick_o));

/* bench/bvs_stepper_test.sv */
// self-checking bench: random and corner button holds on the stepper.
// assumes divider values 2 and 4, so a half tick is 8 clocks.
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, a); end end
module bvs_stepper_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic vres_n = 1'b1;
   logic mute_n = 1'b1;
   logic pd_n = 1'b1;
   logic [1:0] press = 2'h0;
   logic rn, ln, oe, be, ht;
   logic [5:0] step, exp_g;
   logic signed [10:0] db;
   int n_mismatch = 0;
   int samples_checked = 0;
   int cyc = 0;
   int cyc0 = 0;
   int seed = 32'hDE4F6CE8;
   int ntab[8] = '{6, 7, 25, 26, 30, 1, 9, 40};
   initial forever #12.5 mclk_i = ~mclk_i;
   bvs_button_model i_bvs_button_model (.press_i(press), .volume_raise_n_o(rn), .volume_lower_n_o(ln));
   bvs_stepper #(.CLK_PER_OSC(2), .OSC_PER_HALF_TICK(4)) i_bvs_stepper (.mclk_i(mclk_i), .rst_i(rst_i),
      .volume_raise_n_i(rn), .volume_lower_n_i(ln), .volume_reset_n_i(vres_n), .mute_n_i(mute_n),
      .power_down_n_i(pd_n), .gain_step_o(step), .gain_db_x10_o(db), .outputs_enable_o(oe),
      .bias_enable_o(be), .half_tick_o(ht));
   // =====================================================
   // steps expected after k half ticks of hold, clamped at both ends
   function automatic logic [5:0] nxt(logic [5:0] g, logic [1:0] p, int k);
      int s;
      s = (k < 7) ? 0 : (k < 26) ? 1 : 2 + (k - 26) / 4;
      s = (p == 2'h1) ? g + s : (p == 2'h2) ? g - s : g;
      return (s > 63) ? 6'h3F : (s < 0) ? 6'h00 : 6'(s);
   endfunction
   task automatic hold(input logic [1:0] p, input int k);
      @(posedge ht);
      @(negedge mclk_i);
      press = p;
      repeat (k) @(posedge ht);
      @(negedge mclk_i);
      press = 2'h0;
      repeat (4) @(negedge mclk_i);
      exp_g = pd_n ? nxt(exp_g, p, k) : exp_g;
      `CHK("gain_step", exp_g, step)
      `CHK("outputs_enable", mute_n & pd_n, oe)
      `CHK("bias_enable", pd_n, be)
      $display("hold %0h for %0d half ticks done", p, k);
   endtask
   task end_of_test;
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // hang guard: the run needs about 7000 clocks
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial begin
      exp_g = bvs_pkg::STEP_RESET;
      repeat (4) @(negedge mclk_i);
      rst_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      `CHK("reset_step", bvs_pkg::STEP_RESET, step)
      `CHK("reset_db", 11'h01A, db)
      // half tick period is the product of the two bench divider values
      @(posedge ht);
      cyc0 = cyc;
      @(posedge ht);
      `CHK("half_tick_period", 8, cyc - cyc0)
      for (int i = 0; i < 16; i++) begin
         mute_n = (i < 4) | 1'($random(seed));
         pd_n = (i < 4) | (($random(seed) & 3) != 0);
         hold((i < 4) ? 2'(i) : 2'($random(seed)), (i < 8) ? ntab[i] : 1 + {$random(seed)} % 40);
      end
      pd_n = 1'b1;
      mute_n = 1'b1;
      // 280 half ticks give 65 steps, enough to reach either end from anywhere
      hold(2'h1, 280);
      `CHK("db_top", 11'h0EE, db)
      hold(2'h2, 280);
      `CHK("db_bottom", 11'h512, db)
      vres_n = 1'b0;
      repeat (3) @(negedge mclk_i);
      vres_n = 1'b1;
      `CHK("volume_reset", bvs_pkg::STEP_RESET, step)
      end_of_test();
   end
endmodule
